// [src/lcdcd_pkg.sv]
package lcdcd_pkg;

  // serial word layout: register select above the data byte
  localparam int WORD_W = 10;
  localparam int DATA_W = 8;
  localparam int RSEL_LSB = 8;
  localparam int LEVEL_W = 7;
  localparam int GPO_N = 6;
  localparam int MODE_W = 4;
  localparam int BITCNT_W = 4;
  localparam int CNT_W = 21;

  // register select codes
  localparam logic [1:0] RSEL_CMD = 2'h0;
  localparam logic [1:0] RSEL_RAM = 2'h1;
  localparam logic [1:0] RSEL_PWM = 2'h2;

  // fixed opcodes and opcode prefixes
  localparam logic [7:0] OPC_INIT = 8'h16;
  localparam logic [7:0] OPC_CAL_REFRESH = 8'hf0;
  localparam logic [6:0] OPC_PWM_INV_HI = 7'h0a;
  localparam logic [3:0] OPC_MODE_HI = 4'h5;
  localparam logic [4:0] OPC_OSC_HI = 5'h03;
  localparam logic [5:0] OPC_MUX_HI = 6'h00;
  localparam logic [5:0] OPC_BIAS_HI = 6'h01;
  localparam logic [2:0] OPC_FRAME_LCD_HI = 3'h1;
  localparam logic [3:0] OPC_FRAME_PWM_HI = 4'h4;
  localparam logic [3:0] OPC_GPO_STATIC_HI = 4'h6;
  localparam logic [1:0] OPC_PTR_LCD_HI = 2'h2;
  localparam logic [4:0] OPC_PTR_PWM_HI = 5'h0e;
  localparam logic [3:0] OPC_GPO_CFG0_HI = 4'hc;
  localparam logic [3:0] OPC_GPO_CFG1_HI = 4'hd;
  localparam logic [3:0] OPC_GPO_CFG2_HI = 4'he;

  // field positions
  localparam int PWM_INV_BIT = 0;
  localparam int PWM_DATA_TOP = 7;
  localparam int MODE_BIT_PLACE = 3;
  localparam int MODE_BIT_SCHEME = 2;
  localparam int MODE_BIT_PD = 1;
  localparam int MODE_BIT_DISP = 0;

  // reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic PWM_INV_RESET = 1'b0;

  // timing
  localparam int CORE_CLK_HZ = 40_000_000;
  localparam int INIT_TIME_US = 1000;
  localparam int CAL_TIME_MS = 30;
  localparam int INIT_CYCLES = INIT_TIME_US * (CORE_CLK_HZ / 1_000_000);
  localparam int CAL_CYCLES = CAL_TIME_MS * (CORE_CLK_HZ / 1000);

  typedef enum logic {CORE_RUN, CORE_INIT} lcdcd_core_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_PENDING, CAL_RUN} lcdcd_cal_t;

  // true for any of the defined control opcodes
  function automatic logic lcdcd_is_defined(input logic [DATA_W-1:0] b);
    lcdcd_is_defined = (b == OPC_INIT) || (b == OPC_CAL_REFRESH)
      || (b[7:1] == OPC_PWM_INV_HI) || (b[7:4] == OPC_MODE_HI)
      || (b[7:3] == OPC_OSC_HI) || (b[7:2] == OPC_MUX_HI)
      || (b[7:2] == OPC_BIAS_HI) || (b[7:5] == OPC_FRAME_LCD_HI)
      || (b[7:4] == OPC_FRAME_PWM_HI) || (b[7:4] == OPC_GPO_STATIC_HI)
      || (b[7:6] == OPC_PTR_LCD_HI) || (b[7:3] == OPC_PTR_PWM_HI)
      || (b[7:4] == OPC_GPO_CFG0_HI) || (b[7:4] == OPC_GPO_CFG1_HI)
      || (b[7:4] == OPC_GPO_CFG2_HI);
  endfunction

endpackage

// [src/lcdcd_link_if.sv]
`timescale 1ns/1ps
interface lcdcd_link_if;
  import lcdcd_pkg::*;
  logic [WORD_W-1:0] word;
  logic toggle;
  modport rx (output word, output toggle);
  modport core (input word, input toggle);
endinterface

// [src/lcdcd_link_rx.sv]
`timescale 1ns/1ps
module lcdcd_link_rx
  import lcdcd_pkg::*;
(
  input wire logic link_clk_in,  // link clock, runs only in frames
  input wire logic arst_n_in,    // chip reset, active low
  input wire logic sel_n_in,     // frame select, active low
  input wire logic data_in,      // serial data, msb first
  lcdcd_link_if.rx link          // word and toggle to core
);

  logic [WORD_W-1:0] shift;
  logic [BITCNT_W-1:0] bit_cnt;
  logic [WORD_W-1:0] word;
  logic toggle;
  logic [WORD_W-1:0] next_shift;
  logic [BITCNT_W-1:0] next_bit_cnt;
  logic [WORD_W-1:0] next_word;
  logic next_toggle;
  logic frame_rst_n;

  // the clock stops between frames, so the frame's own select ends it
  assign frame_rst_n = arst_n_in & ~sel_n_in;

  // shift one bit per edge; every tenth bit completes a word
  always_comb
  begin
    next_shift = {shift[WORD_W-2:0], data_in};
    next_word = word;
    next_toggle = toggle;
    if (bit_cnt == BITCNT_W'(WORD_W - 1))
    begin
      next_bit_cnt = '0;
      next_word = next_shift;
      next_toggle = ~toggle;
    end
    else
    begin
      next_bit_cnt = bit_cnt + 1'b1;
    end
  end

  // bit position is dropped when a frame closes mid-word
  always_ff @(posedge link_clk_in or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      shift <= '0;
      bit_cnt <= '0;
    end
    else
    begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
    end
  end

  // word is held until the next one completes, so the core sees it stable
  always_ff @(posedge link_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      word <= '0;
      toggle <= 1'b0;
    end
    else
    begin
      word <= next_word;
      toggle <= next_toggle;
    end
  end

  assign link.word = word;
  assign link.toggle = toggle;

endmodule // lcdcd_link_rx

// [src/lcdcd_top.sv]
`timescale 1ns/1ps
module lcdcd_top
  import lcdcd_pkg::*;
#(
  parameter int INIT_CYCLES_P = INIT_CYCLES,
  parameter int CAL_CYCLES_P = CAL_CYCLES
)
(
  input wire logic CORE_CLK_IN,                // core clock, 40 MHz
  input wire logic ARST_N_IN,                  // async reset, active low
  input wire logic LINK_CLK_IN,                // serial link clock
  input wire logic LINK_SEL_N_IN,              // link frame select, active low
  input wire logic LINK_DATA_IN,               // link serial data
  input wire logic CLOCK_AVAILABLE_IN,         // device clock present
  input wire logic [GPO_N-1:0] PWM_WAVE_IN,    // raw pwm waveforms
  input wire logic [GPO_N-1:0] CHANNEL_PWM_MODE_IN, // channel uses pwm
  input wire logic [GPO_N-1:0] STATIC_LEVEL_IN, // stored static levels
  output logic PWM_INVERT_FLAG_OUT,            // pwm invert flag
  output logic BACKPLANE_PLACEMENT_OUT,        // backplane placement
  output logic INVERSION_SCHEME_OUT,           // 1 = frame-wise
  output logic POWER_DOWN_BIT_OUT,             // power-down bit
  output logic DISPLAY_SWITCH_OUT,             // display switch bit
  output logic LCD_DRIVE_EN_OUT,               // lcd outputs driven
  output logic OSC_RUN_OUT,                    // internal oscillator on
  output logic CHIP_RESET_OUT,                 // initialize reset active
  output logic CAL_BUSY_OUT,                   // refresh pending or running
  output logic CAL_LOAD_OUT,                   // refresh done pulse
  output logic RAM_WRITE_OUT,                  // display data strobe
  output logic [DATA_W-1:0] RAM_DATA_OUT,      // display data byte
  output logic PWM_WRITE_OUT,                  // pwm level strobe
  output logic [LEVEL_W-1:0] PWM_LEVEL_OUT,    // pwm level
  output logic CMD_STROBE_OUT,                 // other defined command
  output logic [DATA_W-1:0] CMD_BYTE_OUT,      // its control byte
  output logic [GPO_N-1:0] GPO_OUT             // general purpose outputs
);

  lcdcd_link_if link ();

  lcdcd_link_rx u_rx (
    .link_clk_in(LINK_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .sel_n_in(LINK_SEL_N_IN),
    .data_in(LINK_DATA_IN),
    .link(link.rx)
  );

  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic clk_av_s1;
  logic clk_av_s2;
  logic accept;
  logic [1:0] rsel;
  logic [DATA_W-1:0] byte_in;
  lcdcd_core_t core_state;
  lcdcd_core_t next_core_state;
  lcdcd_cal_t cal_state;
  lcdcd_cal_t next_cal_state;
  logic [CNT_W-1:0] init_cnt;
  logic [CNT_W-1:0] next_init_cnt;
  logic [CNT_W-1:0] cal_cnt;
  logic [CNT_W-1:0] next_cal_cnt;
  logic [MODE_W-1:0] display_mode_cmd;
  logic [MODE_W-1:0] next_display_mode_cmd;
  logic pwm_invert_flag;
  logic next_pwm_invert_flag;
  logic cal_load;
  logic next_cal_load;
  logic ram_wr;
  logic next_ram_wr;
  logic [DATA_W-1:0] ram_data;
  logic [DATA_W-1:0] next_ram_data;
  logic pwm_wr;
  logic next_pwm_wr;
  logic [LEVEL_W-1:0] pwm_level;
  logic [LEVEL_W-1:0] next_pwm_level;
  logic cmd_stb;
  logic next_cmd_stb;
  logic [DATA_W-1:0] cmd_byte;
  logic [DATA_W-1:0] next_cmd_byte;
  logic [GPO_N-1:0] gpo;
  logic [GPO_N-1:0] next_gpo;
  logic lcd_en;
  logic next_lcd_en;

  // toggle crossing plus clock-present level, two flops before any use
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      clk_av_s1 <= 1'b0;
      clk_av_s2 <= 1'b0;
    end
    else
    begin
      tog_s1 <= link.toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      clk_av_s1 <= CLOCK_AVAILABLE_IN;
      clk_av_s2 <= clk_av_s1;
    end
  end

  // word changes on the same link edge as its toggle and then holds until the next word completes
  assign accept = tog_s2 ^ tog_s3;
  assign rsel = link.word[WORD_W-1:RSEL_LSB];
  assign byte_in = link.word[DATA_W-1:0];

  // command decode, reset sequence and calibration refresh
  always_comb
  begin
    next_core_state = core_state;
    next_init_cnt = init_cnt;
    next_cal_state = cal_state;
    next_cal_cnt = cal_cnt;
    next_display_mode_cmd = display_mode_cmd;
    next_pwm_invert_flag = pwm_invert_flag;
    next_cal_load = 1'b0;
    next_ram_wr = 1'b0;
    next_ram_data = ram_data;
    next_pwm_wr = 1'b0;
    next_pwm_level = pwm_level;
    next_cmd_stb = 1'b0;
    next_cmd_byte = cmd_byte;
    // refresh counts only while a clock is present
    case (cal_state)
      CAL_IDLE: ;
      CAL_PENDING:
        if (clk_av_s2)
          next_cal_state = CAL_RUN;
      CAL_RUN:
        if (clk_av_s2)
        begin
          if (cal_cnt == CNT_W'(CAL_CYCLES_P - 1))
          begin
            next_cal_state = CAL_IDLE;
            next_cal_cnt = '0;
            next_cal_load = 1'b1;
          end
          else
          begin
            next_cal_cnt = cal_cnt + 1'b1;
          end
        end
      default: next_cal_state = CAL_IDLE;
    endcase
    case (core_state)
      CORE_RUN:
        if (accept)
        begin
          case (rsel)
            RSEL_CMD:
              if (byte_in == OPC_INIT)
              begin
                next_core_state = CORE_INIT;
                next_init_cnt = '0;
                next_display_mode_cmd = MODE_RESET;
                next_pwm_invert_flag = PWM_INV_RESET;
                next_cal_state = CAL_IDLE;
                next_cal_cnt = '0;
                next_cal_load = 1'b0;
              end
              else if (byte_in == OPC_CAL_REFRESH)
              begin
                // a repeat while busy is absorbed by the running cycle
                if (cal_state == CAL_IDLE)
                  next_cal_state = clk_av_s2 ? CAL_RUN : CAL_PENDING;
              end
              else if (byte_in[7:1] == OPC_PWM_INV_HI)
                next_pwm_invert_flag = byte_in[PWM_INV_BIT];
              else if (byte_in[7:4] == OPC_MODE_HI)
                next_display_mode_cmd = byte_in[MODE_W-1:0];
              else if (lcdcd_is_defined(byte_in))
              begin
                next_cmd_stb = 1'b1;
                next_cmd_byte = byte_in;
              end
            RSEL_RAM:
            begin
              next_ram_wr = 1'b1;
              next_ram_data = byte_in;
            end
            RSEL_PWM:
              if (!byte_in[PWM_DATA_TOP])
              begin
                next_pwm_wr = 1'b1;
                next_pwm_level = byte_in[LEVEL_W-1:0];
              end
            default: ;
          endcase
        end
      CORE_INIT:
        // bytes arriving during the reset sequence are dropped
        if (init_cnt == CNT_W'(INIT_CYCLES_P - 1))
          next_core_state = CORE_RUN;
        else
          next_init_cnt = init_cnt + 1'b1;
      default: next_core_state = CORE_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      core_state <= CORE_RUN;
      init_cnt <= '0;
      cal_state <= CAL_IDLE;
      cal_cnt <= '0;
      display_mode_cmd <= MODE_RESET;
      pwm_invert_flag <= PWM_INV_RESET;
      cal_load <= 1'b0;
      ram_wr <= 1'b0;
      ram_data <= '0;
      pwm_wr <= 1'b0;
      pwm_level <= '0;
      cmd_stb <= 1'b0;
      cmd_byte <= '0;
    end
    else
    begin
      core_state <= next_core_state;
      init_cnt <= next_init_cnt;
      cal_state <= next_cal_state;
      cal_cnt <= next_cal_cnt;
      display_mode_cmd <= next_display_mode_cmd;
      pwm_invert_flag <= next_pwm_invert_flag;
      cal_load <= next_cal_load;
      ram_wr <= next_ram_wr;
      ram_data <= next_ram_data;
      pwm_wr <= next_pwm_wr;
      pwm_level <= next_pwm_level;
      cmd_stb <= next_cmd_stb;
      cmd_byte <= next_cmd_byte;
    end
  end

  // output stage: the display switch never touches the gpo path
  always_comb
  begin
    next_lcd_en = display_mode_cmd[MODE_BIT_DISP]
      & ~display_mode_cmd[MODE_BIT_PD];
    for (int i = 0; i < GPO_N; i++)
    begin
      if (CHANNEL_PWM_MODE_IN[i] && !display_mode_cmd[MODE_BIT_PD])
        next_gpo[i] = PWM_WAVE_IN[i] ^ pwm_invert_flag;
      else
        next_gpo[i] = STATIC_LEVEL_IN[i];
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      lcd_en <= 1'b0;
      gpo <= '0;
    end
    else
    begin
      lcd_en <= next_lcd_en;
      gpo <= next_gpo;
    end
  end

  assign PWM_INVERT_FLAG_OUT = pwm_invert_flag;
  assign BACKPLANE_PLACEMENT_OUT = display_mode_cmd[MODE_BIT_PLACE];
  assign INVERSION_SCHEME_OUT = display_mode_cmd[MODE_BIT_SCHEME];
  assign POWER_DOWN_BIT_OUT = display_mode_cmd[MODE_BIT_PD];
  assign DISPLAY_SWITCH_OUT = display_mode_cmd[MODE_BIT_DISP];
  assign OSC_RUN_OUT = ~display_mode_cmd[MODE_BIT_PD];
  assign LCD_DRIVE_EN_OUT = lcd_en;
  assign CHIP_RESET_OUT = (core_state == CORE_INIT);
  assign CAL_BUSY_OUT = (cal_state != CAL_IDLE);
  assign CAL_LOAD_OUT = cal_load;
  assign RAM_WRITE_OUT = ram_wr;
  assign RAM_DATA_OUT = ram_data;
  assign PWM_WRITE_OUT = pwm_wr;
  assign PWM_LEVEL_OUT = pwm_level;
  assign CMD_STROBE_OUT = cmd_stb;
  assign CMD_BYTE_OUT = cmd_byte;
  assign GPO_OUT = gpo;

  // checks on the core clock
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  a_undef_ignored: assert property (
    accept && !CHIP_RESET_OUT && rsel == RSEL_CMD && !lcdcd_is_defined(byte_in)
    |=> $stable(display_mode_cmd) && $stable(pwm_invert_flag) && !CMD_STROBE_OUT
      && (!CAL_BUSY_OUT || $past(CAL_BUSY_OUT)))
    else $error("undefined control byte changed state");

  a_init_clears: assert property (
    accept && !CHIP_RESET_OUT && rsel == RSEL_CMD && byte_in == OPC_INIT
    |=> CHIP_RESET_OUT && display_mode_cmd == MODE_RESET && !PWM_INVERT_FLAG_OUT
      && !CAL_BUSY_OUT)
    else $error("initialize did not reset settings");

  a_init_length: assert property (
    $fell(CHIP_RESET_OUT) |-> $past(init_cnt) == CNT_W'(INIT_CYCLES_P - 1))
    else $error("reset sequence ended at wrong count");

  a_pwm_inv_set: assert property (
    accept && !CHIP_RESET_OUT && rsel == RSEL_CMD && byte_in[7:1] == OPC_PWM_INV_HI
    |=> PWM_INVERT_FLAG_OUT == $past(byte_in[PWM_INV_BIT]))
    else $error("pwm invert flag not taken from bit 0");

  a_mode_update: assert property (
    accept && !CHIP_RESET_OUT && rsel == RSEL_CMD && byte_in[7:4] == OPC_MODE_HI
    |=> {BACKPLANE_PLACEMENT_OUT, INVERSION_SCHEME_OUT, POWER_DOWN_BIT_OUT,
      DISPLAY_SWITCH_OUT} == $past(byte_in[MODE_W-1:0]) ##1 LCD_DRIVE_EN_OUT
      == (DISPLAY_SWITCH_OUT && !POWER_DOWN_BIT_OUT))
    else $error("mode settings not applied");

  a_pd_static: assert property (
    POWER_DOWN_BIT_OUT ##1 POWER_DOWN_BIT_OUT |-> GPO_OUT == $past(STATIC_LEVEL_IN))
    else $error("gpo not static during power-down");

  a_pd_outputs: assert property (
    $rose(POWER_DOWN_BIT_OUT) |-> !OSC_RUN_OUT ##1 !LCD_DRIVE_EN_OUT)
    else $error("power-down left lcd or oscillator running");

  a_cal_pending: assert property (
    cal_state == CAL_PENDING && !clk_av_s2 && !accept |=> cal_state == CAL_PENDING)
    else $error("pending refresh lost without clock");

  a_cal_length: assert property (
    $fell(CAL_BUSY_OUT) && !$past(CHIP_RESET_OUT) && !CHIP_RESET_OUT
    |-> CAL_LOAD_OUT && $past(cal_cnt) == CNT_W'(CAL_CYCLES_P - 1))
    else $error("refresh ended at wrong count");

  a_ram_route: assert property (
    accept && !CHIP_RESET_OUT && rsel == RSEL_RAM
    |=> RAM_WRITE_OUT && RAM_DATA_OUT == $past(byte_in) && !PWM_WRITE_OUT)
    else $error("ram byte not routed");

endmodule // lcdcd_top

// [testbench/lcdcd_host_model.sv]
`timescale 1ns/1ps
// host side of the serial link, one word per frame
module lcdcd_host_model
(
  output logic link_clk_out, // link clock, still outside frames
  output logic sel_n_out,    // frame select, active low
  output logic data_out      // serial data, msb first
);
  // idle link: clock low, frame closed
  initial
  begin
    link_clk_out = 1'b0;
    sel_n_out = 1'b1;
    data_out = 1'b1;
  end

  // data moves after the falling edge so it is settled at the sampling edge
  // first n bits of a word, then the frame closes; n = 10 is a whole word
  task automatic send_part(input logic [9:0] w, input int n);
    integer i;
    #7;
    sel_n_out = 1'b0;
    for (i = 9; i >= 10 - n; i--)
    begin
      data_out = w[i];
      #80;
      link_clk_out = 1'b1;
      #80;
      link_clk_out = 1'b0;
    end
    sel_n_out = 1'b1;
    // released line shows the inverse so a stale bit cannot pass for data
    data_out = ~w[10 - n];
    #200;
  endtask

  task automatic send_word(input logic [9:0] w);
    send_part(w, 10);
  endtask
endmodule // lcdcd_host_model

// [testbench/tb_lcd_pwm_command_decoder.sv]
`timescale 1ns/1ps
module tb_lcd_pwm_command_decoder;
  import lcdcd_pkg::*;
  localparam int INIT_N = 8;
  localparam int CAL_N = 16;
  logic core_clk, arst_n, link_clk, link_sel_n, link_data, clk_avail;
  logic [GPO_N-1:0] pwm_wave, pwm_mode, static_lvl, gpo;
  logic invert_flag, placement, scheme, power_down, disp_switch, lcd_drive, osc_run;
  logic chip_reset, cal_busy, cal_load, ram_write, pwm_write, cmd_strobe;
  logic [DATA_W-1:0] ram_data, cmd_byte;
  logic [LEVEL_W-1:0] pwm_level;
  int err_count, n_checks, cycles, n_cmd, n_ram, n_pwm, n_load, n_init, k, c;
  logic [3:0] md;
  logic inversion_scheme;
  logic [7:0] defs [11] = '{8'h18, 8'h00, 8'h04, 8'h20, 8'h40, 8'h60, 8'h80, 8'h70, 8'hc0,
    8'hd0, 8'he0};
  logic [7:0] undefs [4] = '{8'h10, 8'h17, 8'h78, 8'hff};

  lcdcd_top #(.INIT_CYCLES_P(INIT_N), .CAL_CYCLES_P(CAL_N)) dut (
    .CORE_CLK_IN(core_clk), .ARST_N_IN(arst_n), .LINK_CLK_IN(link_clk),
    .LINK_SEL_N_IN(link_sel_n), .LINK_DATA_IN(link_data), .CLOCK_AVAILABLE_IN(clk_avail),
    .PWM_WAVE_IN(pwm_wave), .CHANNEL_PWM_MODE_IN(pwm_mode), .STATIC_LEVEL_IN(static_lvl),
    .PWM_INVERT_FLAG_OUT(invert_flag), .BACKPLANE_PLACEMENT_OUT(placement),
    .INVERSION_SCHEME_OUT(scheme), .POWER_DOWN_BIT_OUT(power_down),
    .DISPLAY_SWITCH_OUT(disp_switch), .LCD_DRIVE_EN_OUT(lcd_drive), .OSC_RUN_OUT(osc_run),
    .CHIP_RESET_OUT(chip_reset), .CAL_BUSY_OUT(cal_busy), .CAL_LOAD_OUT(cal_load),
    .RAM_WRITE_OUT(ram_write), .RAM_DATA_OUT(ram_data), .PWM_WRITE_OUT(pwm_write),
    .PWM_LEVEL_OUT(pwm_level), .CMD_STROBE_OUT(cmd_strobe), .CMD_BYTE_OUT(cmd_byte),
    .GPO_OUT(gpo));

  lcdcd_host_model host (.link_clk_out(link_clk), .sel_n_out(link_sel_n), .data_out(link_data));

  // core clock, 40 mhz
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // strobes stand one cycle, so every edge is counted; also the hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cmd_strobe === 1'b1) n_cmd++;
    if (ram_write === 1'b1) n_ram++;
    if (pwm_write === 1'b1) n_pwm++;
    if (cal_load === 1'b1) n_load++;
    if (chip_reset === 1'b1) n_init++;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // waits past the accept latency, then samples off the edge
  task automatic send(input logic [9:0] w);
    host.send_word(w);
    repeat (12) @(posedge core_clk);
    #1;
  endtask

  // expected gpo: live pwm channels follow the wave, the rest hold static
  function automatic logic [GPO_N-1:0] exp_gpo();
    logic [GPO_N-1:0] live;
    live = pwm_mode & {GPO_N{~md[1]}};
    return (live & (pwm_wave ^ {GPO_N{inversion_scheme}})) | (~live & static_lvl);
  endfunction

  task automatic chk_state();
    check("placement", placement, md[3]);
    check("scheme", scheme, md[2]);
    check("power down", power_down, md[1]);
    check("osc run", osc_run, !md[1]);
    check("display", disp_switch, md[0]);
    check("lcd drive", lcd_drive, md[0] && !md[1]);
    check("invert", invert_flag, inversion_scheme);
    check("gpo", gpo, exp_gpo());
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    clk_avail = 1'b0;
    pwm_wave = 6'h2d;
    pwm_mode = 6'h1b;
    static_lvl = 6'h35;
    md = 4'h0;
    inversion_scheme = 1'b0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk_state();
    check("chip reset", chip_reset, 1'b0);
    $display("test reset done");
    // refresh first after reset, before any display enable
    send(10'h0f0);
    check("cal pending", cal_busy, 1'b1);
    send(10'h0f0);
    check("held load", 16'(n_load), 16'h0);
    @(posedge core_clk) clk_avail <= 1'b1;
    k = 0;
    while (n_load == 0 && k < 200)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check("cal time", 16'(k >= CAL_N && k <= CAL_N + 5), 16'h1);
    check("one load", 16'(n_load), 16'h1);
    check("cal idle", cal_busy, 1'b0);
    $display("test refresh done");
    // every mode combination; placement travels with the enable
    for (int m = 0; m < 16; m++)
    begin
      md = m[3:0];
      send({2'b00, OPC_MODE_HI, md});
      chk_state();
    end
    $display("test mode done");
    inversion_scheme = 1'b1;
    send(10'h015);
    chk_state();
    md = 4'h9;
    send(10'h059);
    chk_state();
    inversion_scheme = 1'b0;
    send(10'h014);
    chk_state();
    md = 4'h0;
    send(10'h050);
    chk_state();
    $display("test invert done");
    foreach (defs[i])
    begin
      c = n_cmd;
      send({2'b00, defs[i]});
      check("cmd strobe", 16'(n_cmd - c), 16'h1);
      check("cmd byte", cmd_byte, defs[i]);
    end
    foreach (undefs[i])
    begin
      c = n_cmd;
      send({2'b00, undefs[i]});
      check("undef strobe", 16'(n_cmd - c), 16'h0);
      chk_state();
    end
    $display("test commands done");
    c = n_cmd;
    send(10'h1a5);
    check("ram count", 16'(n_ram), 16'h1);
    check("ram data", ram_data, 8'ha5);
    send(10'h23c);
    check("pwm count", 16'(n_pwm), 16'h1);
    check("pwm level", pwm_level, 7'h3c);
    send(10'h2bc);
    send(10'h3c3);
    check("pwm refused", 16'(n_pwm), 16'h1);
    check("pwm kept", pwm_level, 7'h3c);
    check("rsel refused", 16'(n_ram + n_cmd - c), 16'h1);
    // a cut frame must not shift the next word out of line
    host.send_part(10'h1ff, 6);
    send(10'h15a);
    check("cut frame dropped", 16'(n_ram), 16'h2);
    check("ram after cut", ram_data, 8'h5a);
    $display("test data done");
    inversion_scheme = 1'b1;
    send(10'h015);
    md = 4'hd;
    send(10'h05d);
    n_init = 0;
    send(10'h016);
    check("init length", 16'(n_init), 16'(INIT_N));
    check("init over", chip_reset, 1'b0);
    md = 4'h0;
    inversion_scheme = 1'b0;
    chk_state();
    // initialize is a reset, so refresh again before the display comes on
    send(10'h0f0);
    check("refresh after init", 16'(n_load), 16'h2);
    md = 4'h9;
    send(10'h059);
    chk_state();
    // pin reset in mid-run clears what the commands set
    @(posedge core_clk) arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    md = 4'h0;
    chk_state();
    $display("test initialize done");
    complete_run();
  end
endmodule // tb_lcd_pwm_command_decoder
